/* File: design/act_pkg.sv */
// shared constants, entry layout and carrier types of the control table
package act_pkg;

    // ==========================================================
    // table geometry
    localparam int          ACT_TABLE_BYTES = 128;
    localparam logic [7:0]  ACT_RAM_BASE    = 8'h40;
    localparam int          ACT_N_ENT       = 43;

    // ==========================================================
    // byte addresses touched by the block's own logic
    localparam logic [6:0] ACT_ADDR_PRODUCT_CODE   = 7'h00;
    localparam logic [6:0] ACT_ADDR_PRODUCT_DETAIL = 7'h02;
    localparam logic [6:0] ACT_ADDR_FIRMWARE_REV   = 7'h06;
    localparam logic [6:0] ACT_ADDR_MOTION_FLOOR   = 7'h18;
    localparam logic [6:0] ACT_ADDR_HEAT_CEILING   = 7'h1F;
    localparam logic [6:0] ACT_ADDR_DRIVE_SWITCH   = 7'h40;
    localparam logic [6:0] ACT_ADDR_LAMP           = 7'h41;
    localparam logic [6:0] ACT_ADDR_REPLY_POLICY   = 7'h44;
    localparam logic [6:0] ACT_ADDR_DEFERRED_CMD   = 7'h45;
    localparam logic [6:0] ACT_ADDR_FAULT_FLAGS    = 7'h46;
    localparam logic [6:0] ACT_ADDR_RAMP_ACCEL     = 7'h6C;
    localparam logic [6:0] ACT_ADDR_RAMP_SPEED     = 7'h70;
    localparam logic [6:0] ACT_ADDR_MS_COUNTER     = 7'h78;
    localparam logic [6:0] ACT_ADDR_IN_MOTION      = 7'h7A;
    localparam logic [6:0] ACT_ADDR_MOTION_DETAIL  = 7'h7B;
    localparam logic [6:0] ACT_ADDR_DUTY_MEASURED  = 7'h7C;
    localparam logic [6:0] ACT_ADDR_AMP_MEASURED   = 7'h7E;

    // ==========================================================
    // timing: one millisecond counter step
    localparam int ACT_CLK_PERIOD_NS = 40;
    localparam int ACT_TICK_NS       = 1000000;
    localparam int ACT_TICK_CYCLES   = ACT_TICK_NS / ACT_CLK_PERIOD_NS;

    // ==========================================================
    // entry list: start address, width in bytes, value after reset, host rw
    localparam int ACT_ENT_ADDR [ACT_N_ENT] = '{
        0, 2, 6, 7, 8, 9, 11, 13, 20, 24, 31, 32, 34, 36, 38,
        40, 44, 48, 52, 63, 64, 65, 68, 69, 70, 76, 78, 80, 82, 84,
        88, 90, 100, 102, 104, 108, 112, 116, 120, 122, 123, 124, 126};
    localparam int ACT_ENT_SIZE [ACT_N_ENT] = '{
        2, 4, 1, 1, 1, 1, 1, 1, 4, 4, 1, 2, 2, 2, 2,
        4, 4, 4, 4, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2,
        2, 2, 2, 2, 4, 4, 4, 4, 2, 1, 1, 2, 2};
    localparam int ACT_ENT_RST [ACT_N_ENT] = '{
        0, 0, 0, 7, 1, 250, 3, 2, 0, 10, 80, 160, 95, 885, 1193,
        32767, 480, 4095, 0, 52, 0, 0, 2, 0, 0, 1920, 50, 0, 0, 800,
        0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    localparam bit ACT_ENT_RW [ACT_N_ENT] = '{
        0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1,
        1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 1, 1, 1, 1, 1,
        1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0};

    // ==========================================================
    // byte image of values after reset, little-endian per entry
    function automatic logic [ACT_TABLE_BYTES-1:0][7:0] act_defaults();
        logic [ACT_TABLE_BYTES-1:0][7:0] img;
        img = '0;
        for (int e = 0; e < ACT_N_ENT; e++) begin
            for (int b = 0; b < ACT_ENT_SIZE[e]; b++) begin
                img[ACT_ENT_ADDR[e] + b] = 8'(ACT_ENT_RST[e] >> (8 * b));
            end
        end
        return img;
    endfunction : act_defaults

    // one bit per byte address: host may write it
    function automatic logic [ACT_TABLE_BYTES-1:0] act_rw_mask();
        logic [ACT_TABLE_BYTES-1:0] m;
        m = '0;
        for (int e = 0; e < ACT_N_ENT; e++) begin
            for (int b = 0; b < ACT_ENT_SIZE[e]; b++) begin
                m[ACT_ENT_ADDR[e] + b] = ACT_ENT_RW[e];
            end
        end
        return m;
    endfunction : act_rw_mask

    localparam logic [ACT_TABLE_BYTES-1:0][7:0] ACT_DEFAULTS = act_defaults();
    localparam logic [ACT_TABLE_BYTES-1:0]      ACT_RW_MASK  = act_rw_mask();

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } act_req_t;

    typedef struct packed {
        logic       ack;
        logic       refused;
        logic [7:0] rdata;
    } act_rsp_t;

    typedef struct packed {
        logic [7:0]  in_motion;
        logic [7:0]  motion_detail;
        logic [7:0]  fault_flags;
        logic [7:0]  deferred_cmd;
        logic [15:0] duty_measured;
        logic [15:0] amp_measured;
    } act_status_t;

    typedef struct packed {
        logic        drive_on;
        logic [7:0]  lamp;
        logic [7:0]  heat_ceiling;
        logic [31:0] motion_floor;
        logic [7:0]  reply_policy;
        logic [31:0] ramp_accel;
        logic [31:0] ramp_speed;
    } act_cfg_t;

    typedef struct packed {
        logic [ACT_TABLE_BYTES-1:0][7:0] mem;
        logic [31:0]                     tick_div;
        act_rsp_t                        rsp;
    } act_state_t;

endpackage : act_pkg

/* File: design/act_table.sv */
// byte-addressed control table of the actuator with retained and volatile areas
//
// What this block does
// R1: read returns byte at host-named address
// R2: host supplies the address in every access
// R3: volatile area reloads defaults at power-up
// R4: retained area keeps written values over reset unless nv_load is high
// R5: retained writes only while drive switch zero
// R6: writes to read-only entries are ignored
// R7: entries are one to four bytes
// R8: heat ceiling at 31, default 80
// R9: motion speed floor at 24, default 10
// R10: reply policy at 68, default 2
// R11: ramp acceleration at 108, default 0
// R12: ramp speed at 112, default 0
// R13: millisecond counter at 120, read-only
// R14: motion detail at 123, zero after power-up
// R15: multi-byte entries are least significant first
`timescale 1ns/100ps
module act_table
    import act_pkg::*;
#(
    // arbitrary identity values
    parameter logic [15:0] PRODUCT_CODE  = 16'h0ABC,
    parameter logic [31:0] PRODUCT_INFO  = 32'h0000_0000,
    parameter logic [7:0]  FIRMWARE_REV  = 8'h01,
    parameter int          TICK_CYCLES   = act_pkg::ACT_TICK_CYCLES
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // reload retained area with factory values during reset
    input  wire logic                nv_load,
    // byte access from the packet engine
    input  wire act_pkg::act_req_t   host_req,
    output act_pkg::act_rsp_t        host_rsp,
    // measurements from the control loop
    input  wire act_pkg::act_status_t loop_status,
    // settings towards the control loop
    output act_pkg::act_cfg_t        loop_cfg
);
    import act_pkg::*;

    act_state_t st;
    act_state_t next_st;

    logic [6:0]  idx;
    logic        mapped;
    logic        allowed;
    logic [15:0] ms_now;

    // ==========================================================
    // access decode
    assign idx     = host_req.addr[6:0];
    assign mapped  = (host_req.addr < 8'(ACT_TABLE_BYTES));
    assign allowed = mapped && ACT_RW_MASK[idx]                   // [R6]
                     && ((host_req.addr >= ACT_RAM_BASE)
                         || (st.mem[ACT_ADDR_DRIVE_SWITCH] == 8'h00)); // [R5]
    assign ms_now  = {st.mem[ACT_ADDR_MS_COUNTER + 7'h01],
                      st.mem[ACT_ADDR_MS_COUNTER]};                // [R15]

    // ==========================================================
    // next state
    always_comb begin
        next_st             = st;
        next_st.rsp.ack     = 1'b0;
        next_st.rsp.refused = 1'b0;

        // host access, one byte per request; the packet engine walks
        // multi-byte entries from the lowest address upward
        if (host_req.valid && !rst) begin                         // [R2] [R7]
            next_st.rsp.ack = 1'b1;
            if (host_req.write) begin
                next_st.rsp.rdata = 8'h00;
                if (allowed) begin
                    next_st.mem[idx] = host_req.wdata;
                end else begin
                    next_st.rsp.refused = 1'b1;
                end
            end else if (mapped) begin
                next_st.rsp.rdata = st.mem[idx];                  // [R1]
            end else begin
                next_st.rsp.rdata = 8'h00;
            end
        end

        // millisecond counter, wraps at 16 bits
        if (st.tick_div >= 32'(TICK_CYCLES - 1)) begin
            next_st.tick_div = 32'h0000_0000;
            {next_st.mem[ACT_ADDR_MS_COUNTER + 7'h01],
             next_st.mem[ACT_ADDR_MS_COUNTER]} = ms_now + 16'h0001; // [R13]
        end else begin
            next_st.tick_div = st.tick_div + 32'h0000_0001;
        end

        // live read-only entries follow the control loop
        next_st.mem[ACT_ADDR_IN_MOTION]     = loop_status.in_motion;
        next_st.mem[ACT_ADDR_MOTION_DETAIL] = loop_status.motion_detail;
        next_st.mem[ACT_ADDR_FAULT_FLAGS]   = loop_status.fault_flags;
        next_st.mem[ACT_ADDR_DEFERRED_CMD]  = loop_status.deferred_cmd;
        {next_st.mem[ACT_ADDR_DUTY_MEASURED + 7'h01],
         next_st.mem[ACT_ADDR_DUTY_MEASURED]} = loop_status.duty_measured;
        {next_st.mem[ACT_ADDR_AMP_MEASURED + 7'h01],
         next_st.mem[ACT_ADDR_AMP_MEASURED]}  = loop_status.amp_measured;

        // power-up: volatile area to defaults, retained area untouched
        // unless a factory reload is asked for
        if (rst) begin
            for (int i = 0; i < ACT_TABLE_BYTES; i++) begin
                if ((i >= int'(ACT_RAM_BASE)) || nv_load) begin   // [R3] [R4]
                    next_st.mem[i] = ACT_DEFAULTS[i]; // [R8] [R9] [R14]
                end
            end
            next_st.tick_div = 32'h0000_0000;
            next_st.rsp      = '0;
        end

        // identity bytes are fixed by hardware
        {next_st.mem[ACT_ADDR_PRODUCT_CODE + 7'h01],
         next_st.mem[ACT_ADDR_PRODUCT_CODE]} = PRODUCT_CODE;
        {next_st.mem[ACT_ADDR_PRODUCT_DETAIL + 7'h03],
         next_st.mem[ACT_ADDR_PRODUCT_DETAIL + 7'h02],
         next_st.mem[ACT_ADDR_PRODUCT_DETAIL + 7'h01],
         next_st.mem[ACT_ADDR_PRODUCT_DETAIL]} = PRODUCT_INFO;
        next_st.mem[ACT_ADDR_FIRMWARE_REV] = FIRMWARE_REV;
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    // ==========================================================
    // outputs, all taken from table flops
    assign host_rsp = st.rsp;

    assign loop_cfg.drive_on     = (st.mem[ACT_ADDR_DRIVE_SWITCH] != 8'h00);
    assign loop_cfg.lamp         = st.mem[ACT_ADDR_LAMP];
    assign loop_cfg.heat_ceiling = st.mem[ACT_ADDR_HEAT_CEILING];  // [R8]
    assign loop_cfg.motion_floor = {st.mem[ACT_ADDR_MOTION_FLOOR + 7'h03],
                                    st.mem[ACT_ADDR_MOTION_FLOOR + 7'h02],
                                    st.mem[ACT_ADDR_MOTION_FLOOR + 7'h01],
                                    st.mem[ACT_ADDR_MOTION_FLOOR]}; // [R9]
    assign loop_cfg.reply_policy = st.mem[ACT_ADDR_REPLY_POLICY];  // [R10]
    assign loop_cfg.ramp_accel   = {st.mem[ACT_ADDR_RAMP_ACCEL + 7'h03],
                                    st.mem[ACT_ADDR_RAMP_ACCEL + 7'h02],
                                    st.mem[ACT_ADDR_RAMP_ACCEL + 7'h01],
                                    st.mem[ACT_ADDR_RAMP_ACCEL]};  // [R11]
    assign loop_cfg.ramp_speed   = {st.mem[ACT_ADDR_RAMP_SPEED + 7'h03],
                                    st.mem[ACT_ADDR_RAMP_SPEED + 7'h02],
                                    st.mem[ACT_ADDR_RAMP_SPEED + 7'h01],
                                    st.mem[ACT_ADDR_RAMP_SPEED]};  // [R12]

endmodule : act_table

/* File: sim/act_host.sv */
// host controller model issuing single byte accesses
`timescale 1ns/100ps
module act_host
    import act_pkg::*;
(
    // clock
    input wire logic              ref_clk,
    // byte access port
    output act_pkg::act_req_t     host_req,
    input wire act_pkg::act_rsp_t host_rsp
);
    import act_pkg::*;
    initial host_req = '0;
    // one byte per access, address always named
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output act_rsp_t rsp);
        @(negedge ref_clk);
        host_req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(posedge ref_clk);
        @(negedge ref_clk);
        rsp = host_rsp;
        // released lines carry no stale value
        host_req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask : access
endmodule : act_host

/* File: sim/act_table_assertions.sv */
// concurrent checks on the ports of the control table
`timescale 1ns/100ps
module act_table_chk
    import act_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 nv_load,
    // host side
    input wire act_pkg::act_req_t    host_req,
    input wire act_pkg::act_rsp_t    host_rsp,
    // control loop side
    input wire act_pkg::act_status_t loop_status,
    input wire act_pkg::act_cfg_t    loop_cfg
);
    import act_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // request shapes
    sequence rd_s;
        host_req.valid && !host_req.write;
    endsequence
    sequence wr_at(logic [7:0] a);
        host_req.valid && host_req.write && host_req.addr == a;
    endsequence
    sequence wr_s;
        host_req.valid && host_req.write;
    endsequence
    // ==========================================================
    // checks
    ack_after_req_a: assert property (host_req.valid |=> host_rsp.ack)
        else $error("no ack one cycle after a request");
    no_stray_ack_a: assert property (!host_req.valid |=> !host_rsp.ack)
        else $error("ack without a request");
    unmapped_read_a: assert property (rd_s ##0 host_req.addr[7]
        |=> host_rsp.rdata == 8'h00) else $error("unmapped read not zero");
    ro_write_a: assert property (wr_s ##0 (host_req.addr inside
        {[8'h00:8'h06], 8'h45, 8'h46, [8'h78:8'h7F]}) |=> host_rsp.refused)
        else $error("read-only write not refused");
    locked_retained_a: assert property (wr_s
        ##0 (host_req.addr < 8'h40 && loop_cfg.drive_on)
        |=> host_rsp.refused && $stable(loop_cfg.heat_ceiling)
        && $stable(loop_cfg.motion_floor)) else $error("locked write landed");
    heat_write_a: assert property (wr_at(8'h1F) ##0 !loop_cfg.drive_on
    |=> !host_rsp.refused && loop_cfg.heat_ceiling == $past(host_req.wdata))
        else $error("heat ceiling write lost");
    accel_msb_a: assert property (wr_at(8'h6F)
        |=> loop_cfg.ramp_accel[31:24] == $past(host_req.wdata))
        else $error("top byte of ramp acceleration wrong");
    drive_write_a: assert property (wr_at(8'h40)
        |=> loop_cfg.drive_on == ($past(host_req.wdata) != 8'h00))
        else $error("drive switch does not follow write");
    reset_values_a: assert property ($fell(rst) |->
        loop_cfg.reply_policy == 8'h02 && loop_cfg.ramp_accel == '0
        && loop_cfg.ramp_speed == '0 && !loop_cfg.drive_on)
        else $error("volatile defaults wrong after reset");
    factory_load_a: assert property ($fell(rst) && $past(nv_load) |->
        loop_cfg.heat_ceiling == 8'h50 && loop_cfg.motion_floor == 32'h0A)
        else $error("factory values wrong after restore");
endmodule : act_table_chk

bind act_table act_table_chk #(.TICK_CYCLES(TICK_CYCLES)) i_act_table_chk (
    .ref_clk(ref_clk), .rst(rst), .nv_load(nv_load), .host_req(host_req),
    .host_rsp(host_rsp), .loop_status(loop_status), .loop_cfg(loop_cfg));

/* File: sim/tb_act_table.sv */
// self-checking bench of the control table against a byte model
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
end
module tb_act_table;
    import act_pkg::*;
    logic        ref_clk;
    logic        rst;
    logic        nv_load;
    act_req_t    host_req;
    act_rsp_t    host_rsp;
    act_status_t loop_status;
    act_cfg_t    loop_cfg;
    act_rsp_t    rsp;
    int          mismatches;
    int          tests_run;
    int          model [128];
    bit          rw [128];
    logic [31:0] seed = 32'h4DE8;
    logic [31:0] w;
    logic [7:0]  t;
    // arbitrary identity values
    localparam logic [15:0] ID_CODE = 16'h5A3C;
    localparam logic [31:0] ID_INFO = 32'h1357_9BDF;
    localparam logic [7:0]  ID_REV  = 8'h2E;

    act_table #(.PRODUCT_CODE(ID_CODE), .PRODUCT_INFO(ID_INFO),
        .FIRMWARE_REV(ID_REV), .TICK_CYCLES(10)) i_act_table (
        .ref_clk(ref_clk), .rst(rst),
        .nv_load(nv_load), .host_req(host_req), .host_rsp(host_rsp),
        .loop_status(loop_status), .loop_cfg(loop_cfg));
    act_host i_act_host (.ref_clk(ref_clk), .host_req(host_req),
        .host_rsp(host_rsp));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // ==========================================================
    // model and helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic reload(input bit full);
        for (int e = 0; e < ACT_N_ENT; e++)
            for (int b = 0; b < ACT_ENT_SIZE[e]; b++) begin
                rw[ACT_ENT_ADDR[e] + b] = ACT_ENT_RW[e];
                if (full || ACT_ENT_ADDR[e] >= 64)
                    model[ACT_ENT_ADDR[e] + b] =
                        (ACT_ENT_RST[e] >> (8 * b)) % 256;
            end
        for (int b = 0; b < 4; b++)
            model[2 + b] = ID_INFO[8*b +: 8];
        model[0] = ID_CODE[7:0];
        model[1] = ID_CODE[15:8];
        model[6] = ID_REV;
        model[122] = loop_status.in_motion;
        model[123] = loop_status.motion_detail;
        model[70] = loop_status.fault_flags;
        model[69] = loop_status.deferred_cmd;
        for (int b = 0; b < 2; b++) begin
            model[124 + b] = loop_status.duty_measured[8*b +: 8];
            model[126 + b] = loop_status.amp_measured[8*b +: 8];
        end
    endtask : reload
    task automatic do_reset(input logic load);
        @(negedge ref_clk);
        rst = 1'b1;
        nv_load = load;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        reload(load);
    endtask : do_reset
    task automatic sweep();
        int ad;
        for (int a = 0; a < 129; a++) begin
            ad = a < 128 ? a : 128 + rnd() % 128;
            if (a < 120 || a > 121) begin
                i_act_host.access(1'b0, 8'(ad), 8'h00, rsp);
                `CHK("ack", 1'b1, rsp.ack)
                `CHK("rdata", 8'(a < 128 ? model[a] : 0), rsp.rdata)
            end
        end
    endtask : sweep
    task automatic wr(input int a, input int d);
        bit ok;
        ok = a < 128 && rw[a] && (a >= 64 || model[64] == 0);
        i_act_host.access(1'b1, 8'(a), 8'(d), rsp);
        `CHK("refused", !ok, rsp.refused)
        if (ok) model[a] = d;
    endtask : wr
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    // ==========================================================
    // scenarios
    initial begin
        rst = 1'b1;
        nv_load = 1'b1;
        loop_status = '0;
        do_reset(1'b1);
        sweep();
        loop_status = {rnd(), rnd()};
        reload(1'b0);
        for (int i = 0; i < 300; i++)
            if (i % 16 == 0) wr(64, rnd() % 2);
            else wr(rnd() % 256, rnd() % 256);
        wr(64, 0);
        w = rnd();
        for (int b = 0; b < 4; b++) begin
            wr(108 + b, w[8*b +: 8]);
            wr(112 + b, ~w[8*b +: 8]);
            wr(24 + b, w[8*b +: 8]);
        end
        `CHK("accel", w, loop_cfg.ramp_accel)
        `CHK("speed", ~w, loop_cfg.ramp_speed)
        `CHK("floor", w, loop_cfg.motion_floor)
        wr(65, w[15:8]);
        wr(68, w[23:16]);
        `CHK("lamp", w[15:8], loop_cfg.lamp)
        `CHK("policy", w[23:16], loop_cfg.reply_policy)
        wr(31, w[7:0]);
        wr(64, 1);
        wr(31, 0);
        wr(120, 5);
        `CHK("heat", w[7:0], loop_cfg.heat_ceiling)
        sweep();
        i_act_host.access(1'b0, 8'h78, 8'h00, rsp);
        t = rsp.rdata;
        repeat (8) @(negedge ref_clk);
        i_act_host.access(1'b0, 8'h78, 8'h00, rsp);
        `CHK("tick", 8'(t + 1), rsp.rdata)
        do_reset(1'b0);
        sweep();
        do_reset(1'b1);
        sweep();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end
endmodule : tb_act_table
